// [src/eid_chan_if.sv]
interface eid_chan_if;
  import eid_pkg::*;

  // steering from the register side
  logic enable;
  logic low_speed;
  logic lf_tick;
  eid_sample_type sample_sel;
  eid_edge_type edge_sel;
  logic pin;
  // results from the channel
  logic filt_level;
  logic set_pulse;

  modport ctl (
    output enable, low_speed, lf_tick, sample_sel, edge_sel, pin,
    input filt_level, set_pulse
  );

  modport chan (
    input enable, low_speed, lf_tick, sample_sel, edge_sel, pin,
    output filt_level, set_pulse
  );

endinterface : eid_chan_if

// [src/eid_channel.sv]
`include "eid_consts.svh"

module eid_channel
  import eid_pkg::*;
#(
  parameter int FILT_LEN = `EID_FILT_LEN
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link to the register side
  eid_chan_if.chan ch
);

  localparam int RUN_W = (FILT_LEN > 2) ? $clog2(FILT_LEN) : 1;

  logic [3:0] div_cnt_q;
  logic [1:0] lf_cnt_q;
  logic [3:0] div_last;
  logic sample_tick;
  logic [RUN_W-1:0] run_cnt_q;
  logic filt_q;
  logic filt_prev_q;
  logic set_q;
  logic rise;
  logic fall;

  // terminal count of the full-speed divider
  always_comb begin
    unique case (ch.sample_sel)
      EID_SAMPLE_DIV1: div_last = `EID_DIV_LAST_1;
      EID_SAMPLE_DIV4: div_last = `EID_DIV_LAST_4;
      EID_SAMPLE_DIV8: div_last = `EID_DIV_LAST_8;
      EID_SAMPLE_DIV16: div_last = `EID_DIV_LAST_16;
    endcase
  end

  // low-speed modes ignore the interval select
  assign sample_tick = ch.low_speed ? (ch.lf_tick && lf_cnt_q == `EID_LF_LAST)
                                    : (div_cnt_q >= div_last);

  // a disabled channel is held cleared, standing in for its stopped clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 4'h0;
    end else if (!ch.enable || ch.low_speed || sample_tick) begin
      div_cnt_q <= 4'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // quarter-rate counter on low-frequency clock edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lf_cnt_q <= 2'h0;
    end else if (!ch.enable) begin
      lf_cnt_q <= 2'h0;
    end else if (ch.lf_tick) begin
      lf_cnt_q <= lf_cnt_q + 2'h1;
    end
  end

  // noise canceller: a new level must survive FILT_LEN samples in a row
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (!ch.enable) begin
      run_cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (sample_tick) begin
      if (ch.pin == filt_q) begin
        run_cnt_q <= '0;
      end else if (run_cnt_q == RUN_W'(FILT_LEN - 1)) begin
        run_cnt_q <= '0;
        filt_q <= ch.pin;
      end else begin
        run_cnt_q <= run_cnt_q + RUN_W'(1);
      end
    end
  end

  // edges only ever come from the filtered level
  assign rise = filt_q && !filt_prev_q;
  assign fall = !filt_q && filt_prev_q;

  // one-cycle set pulse toward the interrupt latch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_prev_q <= 1'b0;
      set_q <= 1'b0;
    end else begin
      filt_prev_q <= filt_q;
      unique case (ch.edge_sel)
        EID_EDGE_RISE: set_q <= ch.enable && rise;
        EID_EDGE_FALL: set_q <= ch.enable && fall;
        EID_EDGE_BOTH: set_q <= ch.enable && (rise || fall);
        EID_EDGE_RSVD: set_q <= 1'b0; // reserved code never triggers
      endcase
    end
  end

  assign ch.filt_level = filt_q;
  assign ch.set_pulse = set_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_reserved_quiet: assert property (
    ch.edge_sel == EID_EDGE_RSVD |=> !set_q) else $error("reserved edge code raised a request");
  a_rise_pulse: assert property (
    ch.enable && ch.edge_sel == EID_EDGE_RISE && rise |=> set_q) else $error("rising edge gave no request");
  a_pulse_single: assert property (
    set_q |=> !set_q) else $error("set pulse longer than one cycle");
  a_filter_on_tick: assert property (
    ch.enable && !sample_tick |=> filt_q == filt_prev_q) else $error("filter moved without a sample");
  a_slow_rate: assert property (
    ch.low_speed && sample_tick |-> ch.lf_tick && lf_cnt_q == `EID_LF_LAST) else $error("bad low-speed sample");
  a_disabled_quiet: assert property (
    !ch.enable |=> !set_q && !filt_q) else $error("disabled channel active");

  c_both_edges: cover property (ch.edge_sel == EID_EDGE_BOTH && set_q && !filt_q);

endmodule : eid_channel

// [src/eid_consts.svh]
`ifndef EID_CONSTS_SVH
`define EID_CONSTS_SVH

// register map, byte addresses on the 12-bit register port
`define EID_ADDR_W 12
`define EID_ADDR_ENABLES 12'hF77
`define EID_ADDR_CTL1 12'hFD8
`define EID_ADDR_LEVELS 12'hFE0
`define EID_ADDR_PENDING 12'hFE1

// field layout
`define EID_NUM_CH 6
`define EID_CTL_SAMPLE_LSB 0
`define EID_CTL_SAMPLE_MSB 1
`define EID_CTL_EDGE_LSB 2
`define EID_CTL_EDGE_MSB 3
`define EID_CTL_LEVEL_BIT 4
`define EID_CHAN_CFG 1

// reset values
`define EID_RESET_BYTE 8'h00
`define EID_RESET_ENABLES 6'h00
`define EID_RESET_FIELD 2'h0

// sample divider terminal counts (divide by 1, 4, 8, 16)
`define EID_DIV_LAST_1 4'h0
`define EID_DIV_LAST_4 4'h3
`define EID_DIV_LAST_8 4'h7
`define EID_DIV_LAST_16 4'hF
// low-frequency clock divided by four in low-speed modes
`define EID_LF_LAST 2'h3
// agreeing samples needed before the filter passes a new level
`define EID_FILT_LEN 3

`endif

// [src/eid_pkg.sv]
package eid_pkg;

  // trigger condition on the filtered signal
  typedef enum logic [1:0] {
    EID_EDGE_RISE = 2'h0,
    EID_EDGE_FALL = 2'h1,
    EID_EDGE_BOTH = 2'h2,
    EID_EDGE_RSVD = 2'h3
  } eid_edge_type;

  // sample interval in full-speed modes
  typedef enum logic [1:0] {
    EID_SAMPLE_DIV1 = 2'h0,
    EID_SAMPLE_DIV4 = 2'h1,
    EID_SAMPLE_DIV8 = 2'h2,
    EID_SAMPLE_DIV16 = 2'h3
  } eid_sample_type;

endpackage : eid_pkg

// [src/eid_top.sv]
// Notes on behaviour
// - filter each pin, then raise selected changes
// - canceller feeds edge detector; never raw pin
// - enable register: six channel enables, reset zero
// - disabled channel stops, drops its control settings
// - enable register bits 7:6 read zero
// - control: interval 1:0, edge 3:2, level 4
// - control register bits 7:5 read zero
// - edge codes rise, fall, both; 11 reserved
// - level flag holds filtered level at request
// - full speed samples at clock/1,4,8,16
// - low speed samples at low clock/4
// - latch holds until accepted or cleared
`include "eid_consts.svh"

module eid_top
  import eid_pkg::*;
#(
  parameter int NUM_CH = `EID_NUM_CH,
  parameter int FILT_LEN = `EID_FILT_LEN
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [`EID_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // external interrupt pins and clocking state
  input wire logic [NUM_CH-1:0] irq_pin,
  input wire logic low_freq_clock,
  input wire logic low_speed_mode,
  // interrupt latch toward the cpu
  input wire logic [NUM_CH-1:0] irq_accept,
  input wire logic [NUM_CH-1:0] irq_clear,
  output logic [NUM_CH-1:0] interrupt_latch,
  output logic [NUM_CH-1:0] irq_set_pulse
);

  logic [NUM_CH-1:0] en_q;
  eid_sample_type sample_q;
  eid_edge_type edge_q;
  logic level_q;
  logic lf_prev_q;
  logic lf_tick;
  logic [NUM_CH-1:0] latch_q;
  logic [NUM_CH-1:0] set_w;
  logic [NUM_CH-1:0] filt_w;
  logic [NUM_CH-1:0] keep_w;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  logic wr_enables;
  logic wr_ctl;

  // address decode for writes
  assign wr_enables = bus_wr && bus_addr == `EID_ADDR_ENABLES;
  assign wr_ctl = bus_wr && bus_addr == `EID_ADDR_CTL1;

  // channel enables, the only gate on each channel
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= `EID_RESET_ENABLES;
    end else if (wr_enables) begin
      en_q <= bus_wdata[NUM_CH-1:0];
    end
  end

  // channel 1 control; nothing is kept while the channel is off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_q <= EID_SAMPLE_DIV1;
      edge_q <= EID_EDGE_RISE;
    end else if (!en_q[`EID_CHAN_CFG]) begin
      sample_q <= EID_SAMPLE_DIV1;
      edge_q <= EID_EDGE_RISE;
    end else if (wr_ctl) begin
      sample_q <= eid_sample_type'(bus_wdata[`EID_CTL_SAMPLE_MSB:`EID_CTL_SAMPLE_LSB]);
      edge_q <= eid_edge_type'(bus_wdata[`EID_CTL_EDGE_MSB:`EID_CTL_EDGE_LSB]);
    end
  end

  // filtered level captured when channel 1 raises a request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'b0;
    end else if (!en_q[`EID_CHAN_CFG]) begin
      level_q <= 1'b0;
    end else if (set_w[`EID_CHAN_CFG]) begin
      level_q <= filt_w[`EID_CHAN_CFG];
    end
  end

  // low-frequency clock is a synchronous input; its rising edge is a tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lf_prev_q <= 1'b0;
    end else begin
      lf_prev_q <= low_freq_clock;
    end
  end

  assign lf_tick = low_freq_clock && !lf_prev_q;

  // one filter and detector per pin
  eid_chan_if ch_if[NUM_CH] ();

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    assign ch_if[g].enable = en_q[g];
    assign ch_if[g].low_speed = low_speed_mode;
    assign ch_if[g].lf_tick = lf_tick;
    assign ch_if[g].pin = irq_pin[g];
    // only channel 1 has a control register here; the rest run at reset settings
    if (g == `EID_CHAN_CFG) begin : g_cfg
      assign ch_if[g].sample_sel = sample_q;
      assign ch_if[g].edge_sel = edge_q;
    end else begin : g_fixed
      assign ch_if[g].sample_sel = EID_SAMPLE_DIV1;
      assign ch_if[g].edge_sel = EID_EDGE_RISE;
    end
    assign set_w[g] = ch_if[g].set_pulse;
    assign filt_w[g] = ch_if[g].filt_level;

    eid_channel #(
      .FILT_LEN(FILT_LEN)
    ) u_chan (
      .clk(clk),
      .rst_b(rst_b),
      .ch(ch_if[g])
    );
  end

  assign irq_set_pulse = set_w;

  // interrupt latch: a set in the clearing cycle is kept
  assign keep_w = latch_q & ~(irq_accept | irq_clear);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= '0;
    end else begin
      latch_q <= keep_w | set_w;
    end
  end

  assign interrupt_latch = latch_q;

  // read mux; unused and unmapped bits read as zero
  always_comb begin
    rd_mux = `EID_RESET_BYTE;
    unique case (bus_addr)
      `EID_ADDR_ENABLES: rd_mux[NUM_CH-1:0] = en_q;
      `EID_ADDR_CTL1: begin
        rd_mux[`EID_CTL_SAMPLE_MSB:`EID_CTL_SAMPLE_LSB] = sample_q;
        rd_mux[`EID_CTL_EDGE_MSB:`EID_CTL_EDGE_LSB] = edge_q;
        rd_mux[`EID_CTL_LEVEL_BIT] = level_q;
      end
      `EID_ADDR_LEVELS: rd_mux[NUM_CH-1:0] = filt_w;
      `EID_ADDR_PENDING: rd_mux[NUM_CH-1:0] = latch_q;
      default: rd_mux = `EID_RESET_BYTE;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= `EID_RESET_BYTE;
    end else if (bus_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= `EID_RESET_BYTE;
    end
  end

  assign bus_rdata = rdata_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_enable_upper_zero: assert property (
    bus_rd && bus_addr == `EID_ADDR_ENABLES |=> bus_rdata[7:NUM_CH] == '0)
    else $error("enable register upper bits not zero");
  a_ctl_upper_zero: assert property (
    bus_rd && bus_addr == `EID_ADDR_CTL1 |=> bus_rdata[7:`EID_CTL_LEVEL_BIT+1] == '0)
    else $error("control register upper bits not zero");
  a_enable_readback: assert property (
    wr_enables ##1 bus_rd && bus_addr == `EID_ADDR_ENABLES |=> bus_rdata[NUM_CH-1:0] == $past(bus_wdata[NUM_CH-1:0], 2))
    else $error("enable register did not read back");
  a_disabled_drop: assert property (
    !en_q[`EID_CHAN_CFG] && wr_ctl |=> sample_q == EID_SAMPLE_DIV1 && edge_q == EID_EDGE_RISE)
    else $error("disabled channel kept a control write");
  a_ctl_store: assert property (
    en_q[`EID_CHAN_CFG] && wr_ctl && !wr_enables |=>
      edge_q == eid_edge_type'($past(bus_wdata[`EID_CTL_EDGE_MSB:`EID_CTL_EDGE_LSB])))
    else $error("control write not stored");
  a_latch_hold: assert property (
    keep_w != '0 |=> (latch_q & $past(keep_w)) == $past(keep_w))
    else $error("latch dropped a held request");
  a_set_wins: assert property (
    set_w != '0 |=> (latch_q & $past(set_w)) == $past(set_w))
    else $error("request lost against a clear");
  a_level_capture: assert property (
    en_q[`EID_CHAN_CFG] && set_w[`EID_CHAN_CFG] && !wr_enables |=> level_q == $past(filt_w[`EID_CHAN_CFG]))
    else $error("level flag did not capture filtered level");
  a_rdata_one_cycle: assert property (
    !bus_rd |=> bus_rdata == `EID_RESET_BYTE)
    else $error("read data stood past its cycle");

  c_ch1_request: cover property (set_w[`EID_CHAN_CFG] && edge_q == EID_EDGE_FALL);
  c_accept: cover property (latch_q[`EID_CHAN_CFG] ##1 irq_accept[`EID_CHAN_CFG]);
  c_set_on_clear: cover property (|(set_w & irq_clear));
  c_slow_request: cover property (low_speed_mode && |set_w);

endmodule : eid_top

// [testbench/eid_pin_model.sv]
module eid_pin_model (
  // gear clock
  input wire logic clk,
  // board side of the interrupt pins
  output logic [5:0] irq_pin,
  output logic low_freq_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  logic lf_run;
  int lf_cnt;

  initial begin
    irq_pin = 6'h00;
    low_freq_clock = 1'b0;
    lf_run = 1'b0;
    lf_cnt = 0;
  end

  // board levels move just after a gear clock edge, held until the next call
  task automatic drive(input int ch, input logic lvl);
    @(posedge clk);
    irq_pin[ch] <= lvl;
  endtask : drive

  // low clock at one eighth of the gear clock; parked low while not running
  always @(posedge clk) begin
    lf_cnt <= (lf_cnt == 3) ? 0 : lf_cnt + 1;
    if (lf_cnt == 3) low_freq_clock <= lf_run & ~low_freq_clock;
  end
endmodule : eid_pin_model

// [testbench/tb_eid_top.sv]
`include "eid_consts.svh"

module tb_eid_top;
  import eid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] bus_addr = 12'h000;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic low_speed_mode = 1'b0;
  logic [5:0] irq_accept = 6'h00;
  logic [5:0] irq_clear = 6'h00;
  wire logic [7:0] bus_rdata;
  wire logic [5:0] irq_pin;
  wire logic low_freq_clock;
  wire logic [5:0] interrupt_latch;
  wire logic [5:0] irq_set_pulse;
  int fails = 0;
  int samples_checked = 0;
  int pc = 0;

  always #12.5 clk = ~clk;

  eid_pin_model pm_u (.clk(clk), .irq_pin(irq_pin), .low_freq_clock(low_freq_clock));

  eid_top #(.NUM_CH(6), .FILT_LEN(3)) dut_u (
    .clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq_pin(irq_pin),
    .low_freq_clock(low_freq_clock), .low_speed_mode(low_speed_mode),
    .irq_accept(irq_accept), .irq_clear(irq_clear),
    .interrupt_latch(interrupt_latch), .irq_set_pulse(irq_set_pulse)
  );

  // counts high cycles, so a stretched pulse shows as a miscount
  always @(posedge clk) if (irq_set_pulse[1] === 1'b1) pc = pc + 1;

  task automatic end_sim;
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk($sformatf("rdata_%h", a), e, bus_rdata);
  endtask : rd

  // move pin 1, then count pulses before the earliest and after the latest time
  task automatic pin_step(input logic lvl, input int early, input int late, input int n);
    #1 pc = 0;
    pm_u.drive(1, lvl);
    repeat (early) @(posedge clk);
    #1 chk("pulses_early", 8'h00, 8'(pc));
    repeat (late - early) @(posedge clk);
    #1 chk("pulses", 8'(n), 8'(pc));
  endtask : pin_step

  task automatic pulse_clear(input logic [5:0] m);
    @(posedge clk);
    irq_clear <= m;
    @(posedge clk);
    irq_clear <= 6'h00;
  endtask : pulse_clear

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(`EID_ADDR_ENABLES, 8'h00);
    rd(`EID_ADDR_CTL1, 8'h00);
    rd(12'h123, 8'h00);
    wr(`EID_ADDR_CTL1, 8'h0E);
    rd(`EID_ADDR_CTL1, 8'h00);
    wr(`EID_ADDR_ENABLES, 8'hFF);
    rd(`EID_ADDR_ENABLES, 8'h3F);
    wr(`EID_ADDR_CTL1, 8'hFF);
    rd(`EID_ADDR_CTL1, 8'h0F);
    pin_step(1'b1, 10, 52, 0);
    wr(`EID_ADDR_CTL1, 8'h00);
    pin_step(1'b0, 2, 7, 0);
    pin_step(1'b1, 2, 7, 1);
    rd(`EID_ADDR_CTL1, 8'h10);
    repeat (20) @(posedge clk);
    #1 chk("latch_held", 8'h02, {2'b00, interrupt_latch});
    pulse_clear(6'h02);
    #1 chk("latch_cleared", 8'h00, {2'b00, interrupt_latch});
    wr(`EID_ADDR_CTL1, 8'h04);
    pin_step(1'b0, 2, 7, 1);
    rd(`EID_ADDR_CTL1, 8'h04);
    pin_step(1'b1, 2, 7, 0);
    wr(`EID_ADDR_CTL1, 8'h08);
    pin_step(1'b0, 2, 7, 1);
    pin_step(1'b1, 2, 7, 1);
    // one-cycle dip must be swallowed by the canceller
    #1 pc = 0;
    pm_u.drive(1, 1'b0);
    pm_u.drive(1, 1'b1);
    repeat (8) @(posedge clk);
    #1 chk("glitch", 8'h00, 8'(pc));
    for (int s = 1; s < 4; s++) begin
      wr(`EID_ADDR_CTL1, 8'h08 | 8'(s));
      pin_step(~s[0], 2 * (2 << s), 3 * (2 << s) + 4, 1);
    end
    // slow mode with divide-by-1 code still samples at low clock / 4
    wr(`EID_ADDR_CTL1, 8'h08);
    low_speed_mode <= 1'b1;
    pm_u.lf_run = 1'b1;
    repeat (96) @(posedge clk);
    pulse_clear(6'h3F);
    pin_step(1'b1, 64, 104, 1);
    low_speed_mode <= 1'b0;
    pm_u.lf_run = 1'b0;
    repeat (60) @(posedge clk);
    pulse_clear(6'h3F);
    // channel 0 is fixed rising, divide by 1; cpu acceptance drops it
    pm_u.drive(0, 1'b1);
    repeat (10) @(posedge clk);
    rd(`EID_ADDR_PENDING, 8'h01);
    rd(`EID_ADDR_LEVELS, 8'h03);
    @(posedge clk);
    irq_accept <= 6'h01;
    @(posedge clk);
    irq_accept <= 6'h00;
    #1 chk("latch_accepted", 8'h00, {2'b00, interrupt_latch});
    wr(`EID_ADDR_ENABLES, 8'h3D);
    rd(`EID_ADDR_CTL1, 8'h00);
    pin_step(1'b0, 2, 10, 0);
    end_sim;
  end

  // whole run takes well under 3000 cycles
  initial begin
    #200000;
    fails++;
    end_sim;
  end
endmodule : tb_eid_top
